// *** rtl/serial_eeprom_i2c_target.sv ***
// Our own choices: the address map and register access over APB.
`include "eeprom_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_target #(
   parameter int unsigned PROG_CYCLES = `PROG_CYCLES,
   // Device type code and identifier contents are arbitrary values.
   parameter logic [3:0] DEV_TYPE = 4'h6,
   parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   logic [7:0] mem [0:`ARRAY_BYTES-1];
   logic [7:0] idpage [0:`PAGE_BYTES-1];
   logic [7:0] pbuf [0:`PAGE_BYTES-1];
   logic [`PAGE_BYTES-1:0] mask;
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic scl_rise, scl_fall, start_c, stop_c;
   eeprom_pkg::link_state_t state;
   logic [3:0] cnt;
   logic [7:0] shreg, outbyte, rd_now;
   logic [15:0] addr, prog_addr;
   logic pull, mack, prog_go, commit;
   logic [31:0] prog_cnt;
   logic [31:0] ctrl;
   eeprom_pkg::status_t status;
   logic dev_match, region_blocked;

   function automatic logic [1:0] region(input logic [15:0] a);
      region = a[15:14];
   endfunction : region

   function automatic logic [7:0] rd_byte(input logic [15:0] a);
      case (region(a))
         `REGION_ARRAY: rd_byte = mem[a[12:0]];
         `REGION_UID: rd_byte = UNIQUE_ID[{~a[3:0], 3'h0} +: 8];
         `REGION_CFG: rd_byte = a[0] ? {6'h00, status.locked, 1'b0} : status.cfg;
         default: rd_byte = idpage[a[4:0]];
      endcase
   endfunction : rd_byte

   // The byte at the pointer, fetched ahead so its first bit can go out on the same falling edge.
   always_comb begin
      rd_now = rd_byte(addr);
   end

   // Three flip-flops on each pin; the decoders compare the second and third stages.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_m <= scl;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_c = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
   assign sda_out = 1'b0;
   assign sda_oe = pull;

   assign dev_match = ctrl[0] && !status.busy && shreg[7:4] == DEV_TYPE
                      && shreg[3:1] == status.cfg[`CFG_ADDR_MSB:`CFG_ADDR_LSB];
   assign region_blocked = (region(addr) == `REGION_ARRAY && status.cfg[`CFG_WP_BIT])
                           || (region(addr) == `REGION_IDPAGE && status.locked)
                           || region(addr) == `REGION_UID;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= eeprom_pkg::st_idle;
         cnt <= 4'h0;
         shreg <= 8'h00;
         outbyte <= 8'h00;
         addr <= 16'h0000;
         pull <= 1'b0;
         mack <= 1'b0;
         mask <= '0;
         prog_go <= 1'b0;
         prog_addr <= 16'h0000;
      end else begin
         prog_go <= 1'b0;
         if (start_c) begin
            state <= eeprom_pkg::st_dev;
            cnt <= 4'h0;
            pull <= 1'b0;
         end else if (stop_c) begin
            // A write ends at the stop; a blocked target simply keeps its old contents.
            if (state == eeprom_pkg::st_write && |mask && !region_blocked) begin
               prog_go <= 1'b1;
               prog_addr <= addr;
            end
            state <= eeprom_pkg::st_idle;
            cnt <= 4'h0;
            pull <= 1'b0;
         end else if (state != eeprom_pkg::st_idle) begin
            if (scl_rise) begin
               if (cnt < 4'h8) begin
                  shreg <= {shreg[6:0], sda_s};
               end else if (state == eeprom_pkg::st_read) begin
                  mack <= ~sda_s;
               end
               cnt <= cnt + 4'h1;
            end else if (scl_fall) begin
               if (cnt == 4'h8) begin
                  pull <= 1'b0;
                  case (state)
                     eeprom_pkg::st_dev: begin
                        if (dev_match) begin
                           pull <= 1'b1;
                           state <= shreg[0] ? eeprom_pkg::st_read : eeprom_pkg::st_addr_hi;
                        end else begin
                           state <= eeprom_pkg::st_idle;
                        end
                     end
                     eeprom_pkg::st_addr_hi: begin
                        addr[15:8] <= shreg;
                        pull <= 1'b1;
                        state <= eeprom_pkg::st_addr_lo;
                     end
                     eeprom_pkg::st_addr_lo: begin
                        addr[7:0] <= shreg;
                        mask <= '0;
                        pull <= 1'b1;
                        state <= eeprom_pkg::st_write;
                     end
                     eeprom_pkg::st_write: begin
                        pbuf[addr[4:0]] <= shreg;
                        mask[addr[4:0]] <= 1'b1;
                        addr[4:0] <= addr[4:0] + 5'h01;
                        pull <= 1'b1;
                     end
                     default: begin
                        pull <= 1'b0;
                     end
                  endcase
               end else if (cnt == 4'h9) begin
                  cnt <= 4'h0;
                  if (state == eeprom_pkg::st_read && mack) begin
                     outbyte <= rd_now;
                     addr <= addr + 16'h0001;
                     pull <= ~rd_now[7];
                  end else begin
                     pull <= 1'b0;
                     if (state == eeprom_pkg::st_read) begin
                        state <= eeprom_pkg::st_idle;
                     end
                  end
               end else if (state == eeprom_pkg::st_read && cnt != 4'h0) begin
                  pull <= ~outbyte[3'(4'h7 - cnt)];
               end
            end
         end
      end
   end

   assign commit = status.busy && prog_cnt == PROG_CYCLES - 1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status.busy <= 1'b0;
         status.locked <= 1'b0;
         status.cfg <= `CFG_RESET;
         prog_cnt <= 32'h0000_0000;
      end else if (prog_go) begin
         status.busy <= 1'b1;
         prog_cnt <= 32'h0000_0000;
      end else if (status.busy) begin
         prog_cnt <= prog_cnt + 32'h0000_0001;
         if (commit) begin
            status.busy <= 1'b0;
            if (region(prog_addr) == `REGION_CFG) begin
               if (mask[0]) begin
                  status.cfg <= pbuf[0];
               end
               if (mask[1] && pbuf[1][`LOCK_BIT]) begin
                  status.locked <= 1'b1;
               end
            end
         end
      end
   end

   // The stores carry no reset: their contents model non-volatile cells.
   always_ff @(posedge pclk) begin
      if (commit) begin
         for (int i = 0; i < `PAGE_BYTES; i++) begin
            if (mask[i] && region(prog_addr) == `REGION_ARRAY) begin
               mem[{prog_addr[12:5], 5'(i)}] <= pbuf[i];
            end
            if (mask[i] && region(prog_addr) == `REGION_IDPAGE) begin
               idpage[i] <= pbuf[i];
            end
         end
      end
   end

   // APB slave: zero wait states, read data latched in the setup cycle.
   assign pready = 1'b1;
   assign pslverr = psel && penable && paddr != `APB_CTRL_OFFSET && paddr != `APB_STATUS_OFFSET;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `CTRL_RESET;
         prdata <= 32'h0000_0000;
      end else begin
         if (psel && penable && pwrite && paddr == `APB_CTRL_OFFSET) begin
            ctrl <= {31'h0000_0000, pwdata[0]};
         end
         if (psel && !penable) begin
            case (paddr)
               `APB_CTRL_OFFSET: prdata <= ctrl;
               `APB_STATUS_OFFSET: prdata <= {22'h00_0000, status};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   property p_ack_on_match;
      @(posedge pclk) disable iff (!presetn)
      scl_fall && cnt == 4'h8 && state == eeprom_pkg::st_dev && !start_c && !stop_c && dev_match |=> sda_oe;
   endproperty
   a_ack_on_match: assert property (p_ack_on_match) else $error("matching address not acknowledged");

   property p_nack_mismatch;
      @(posedge pclk) disable iff (!presetn)
      scl_fall && cnt == 4'h8 && state == eeprom_pkg::st_dev && !start_c && !stop_c
      && shreg[3:1] != status.cfg[3:1] |=> !sda_oe;
   endproperty
   a_nack_mismatch: assert property (p_nack_mismatch) else $error("mismatched address acknowledged");

   property p_ack_whole_clock;
      @(posedge pclk) disable iff (!presetn)
      cnt == 4'h9 && (state == eeprom_pkg::st_addr_hi || state == eeprom_pkg::st_addr_lo
      || state == eeprom_pkg::st_write) |-> sda_oe;
   endproperty
   a_ack_whole_clock: assert property (p_ack_whole_clock) else $error("acknowledge released early");

   property p_oe_moves_on_fall;
      @(posedge pclk) disable iff (!presetn)
      sda_oe != $past(sda_oe) |-> $past(scl_fall) || $past(start_c) || $past(stop_c);
   endproperty
   a_oe_moves_on_fall: assert property (p_oe_moves_on_fall) else $error("data changed off falling edge");

   property p_shift_on_rise;
      @(posedge pclk) disable iff (!presetn)
      shreg != $past(shreg) |-> $past(scl_rise);
   endproperty
   a_shift_on_rise: assert property (p_shift_on_rise) else $error("data captured off rising edge");

   property p_wp_blocks;
      @(posedge pclk) disable iff (!presetn)
      stop_c && state == eeprom_pkg::st_write && region(addr) == `REGION_ARRAY && status.cfg[0]
      && !status.busy |=> ##1 !status.busy;
   endproperty
   a_wp_blocks: assert property (p_wp_blocks) else $error("protected write started programming");

   property p_prog_bounded;
      @(posedge pclk) disable iff (!presetn)
      status.busy |-> prog_cnt < `PROG_CYCLES;
   endproperty
   a_prog_bounded: assert property (p_prog_bounded) else $error("programming cycle too long");

   property p_lock_sticks;
      @(posedge pclk) disable iff (!presetn)
      status.locked |=> status.locked;
   endproperty
   a_lock_sticks: assert property (p_lock_sticks) else $error("identification page unlocked");

   property p_page_roll;
      @(posedge pclk) disable iff (!presetn)
      scl_fall && cnt == 4'h8 && state == eeprom_pkg::st_write && !start_c && !stop_c
      |=> addr[15:5] == $past(addr[15:5]) && addr[4:0] == $past(addr[4:0]) + 5'h01;
   endproperty
   a_page_roll: assert property (p_page_roll) else $error("page write left its page");
endmodule : serial_eeprom_i2c_target
`default_nettype wire

// *** rtl/eeprom_consts.svh ***
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH
`define PCLK_PERIOD_NS 100
`define PROG_TIME_NS 3000000
`define PROG_CYCLES (`PROG_TIME_NS / `PCLK_PERIOD_NS)
`define ARRAY_BYTES 8192
`define PAGE_BYTES 32
`define UID_BYTES 16
`define CFG_RESET 8'h00
`define CFG_WP_BIT 0
`define CFG_ADDR_LSB 1
`define CFG_ADDR_MSB 3
`define LOCK_BIT 1
`define REGION_ARRAY 2'h0
`define REGION_UID 2'h1
`define REGION_CFG 2'h2
`define REGION_IDPAGE 2'h3
`define APB_CTRL_OFFSET 12'h000
`define APB_STATUS_OFFSET 12'h004
`define CTRL_RESET 32'h0000_0001
`endif

// *** rtl/eeprom_pkg.sv ***
package eeprom_pkg;
   typedef enum logic [2:0] {st_idle, st_dev, st_addr_hi, st_addr_lo, st_write, st_read} link_state_t;
   typedef struct packed {
      logic busy;
      logic locked;
      logic [7:0] cfg;
   } status_t;
endpackage : eeprom_pkg

// *** tb/bus_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module bus_master (
   input wire logic pclk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_oe
);
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // A quarter bit of two pclk gives a serial clock period of 800 ns, 1.25 MHz, above the 1 MHz ceiling.
   task automatic q();
      repeat (2) @(posedge pclk);
   endtask : q
   task automatic start();
      q();
      sda_oe <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      sda_oe <= 1'b1;
      q();
      scl <= 1'b0;
   endtask : start
   task automatic stop();
      q();
      sda_oe <= 1'b1;
      q();
      scl <= 1'b1;
      q();
      sda_oe <= 1'b0;
      q();
   endtask : stop
   // Data moves only while the clock is low and is sampled mid-high, away from both edges.
   task automatic bit_x(input logic b, output logic r);
      q();
      sda_oe <= ~b;
      q();
      scl <= 1'b1;
      q();
      @(negedge pclk) r = sda_line;
      q();
      scl <= 1'b0;
   endtask : bit_x
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
      bit_x(last, a);
   endtask : xfer
endmodule : bus_master
`default_nettype wire

// *** tb/test_serial_eeprom_i2c_target.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_i2c_target;
   localparam logic [3:0] dt = 4'h6;
   // Device type code and identifier contents are arbitrary.
   localparam logic [127:0] uid = 128'hA5C3_1F0E_9B27_D46C_8E15_3A70_C2F9_64BD;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, scl, sda_out, sda_oe, m_oe, sda_line;
   int n_errors = 0, tests_run = 0;
   logic [7:0] mem [int];
   logic [2:0] ca = 3'h0;
   always #50 pclk = ~pclk;
   assign sda_line = ~(m_oe | sda_oe);
   serial_eeprom_i2c_target #(.PROG_CYCLES(20), .DEV_TYPE(dt), .UNIQUE_ID(uid)) i_serial_eeprom_i2c_target (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe));
   bus_master i_bus_master (.pclk(pclk), .sda_line(sda_line), .scl(scl), .sda_oe(m_oe));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic end_of_test();
      if (n_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic timeout();
      n_errors++;
      end_of_test();
   endtask : timeout
   always @(posedge pclk) if (sda_oe === 1'b1) chk("sda_out", 32'h0, sda_out);
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) timeout();
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic st(output logic [31:0] r);
      logic e;
      apb(1'b0, 12'h004, 32'h0000_0000, r, e);
   endtask : st
   task automatic dev(input logic [2:0] a3, input logic rw, input logic ea);
      logic [7:0] r;
      logic a;
      i_bus_master.start();
      i_bus_master.xfer({dt, a3, rw}, 1'b1, r, a);
      chk("addr_ack", ea, a);
   endtask : dev
   task automatic seta(input logic [15:0] ad);
      logic [7:0] r;
      logic a;
      dev(ca, 1'b0, 1'b0);
      i_bus_master.xfer(ad[15:8], 1'b1, r, a);
      chk("ack", 32'h0, a);
      i_bus_master.xfer(ad[7:0], 1'b1, r, a);
      chk("ack", 32'h0, a);
   endtask : seta
   task automatic wr(input logic [15:0] ad, input logic [7:0] d [$], input logic prog);
      logic [7:0] r;
      logic a;
      logic [31:0] s;
      int n;
      seta(ad);
      foreach (d[i]) begin
         i_bus_master.xfer(d[i], 1'b1, r, a);
         chk("ack", 32'h0, a);
         if (prog) mem[{ad[15:5], ad[4:0] + 5'(i)}] = d[i];
      end
      i_bus_master.stop();
      repeat (5) @(posedge pclk);
      st(s);
      chk("busy", prog, s[9]);
      n = 0;
      while (s[9] !== 1'b0 && n < 15) begin
         st(s);
         n++;
      end
      if (n >= 15) timeout();
   endtask : wr
   task automatic rd(input logic [15:0] ad, input int n);
      logic [7:0] r;
      logic a;
      seta(ad);
      dev(ca, 1'b1, 1'b0);
      for (int i = 0; i < n; i++) begin
         i_bus_master.xfer(8'hFF, i == n - 1, r, a);
         chk("rdata", mem[int'(ad) + i], r);
      end
      i_bus_master.stop();
   endtask : rd
   initial begin
      logic [31:0] r;
      logic e;
      logic [7:0] d [$];
      logic [15:0] ad;
      void'($urandom(87196));
      for (int i = 0; i < 16; i++) mem[16'h4000 + i] = uid[127 - 8 * i -: 8];
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0000_0000, r, e);
      chk("ctrl", 32'h0000_0001, r);
      st(r);
      chk("status", 32'h0000_0000, r);
      apb(1'b0, 12'h008, 32'h0000_0000, r, e);
      chk("unmapped", 32'h0000_0000, r);
      chk("pslverr", 32'h0000_0001, e);
      // The page write starts two bytes before the page end, so it must wrap to index 0.
      ad = {3'h0, 8'($urandom), 5'h1E};
      repeat (4) d.push_back(8'($urandom));
      wr(ad, d, 1'b1);
      rd(ad, 2);
      rd(ad & 16'hFFE0, 2);
      dev(3'h1, 1'b0, 1'b1);
      i_bus_master.stop();
      d = {8'h0B};
      wr(16'h8000, d, 1'b1);
      ca = 3'h5;
      st(r);
      chk("status", 32'h0000_000B, r);
      dev(3'h0, 1'b0, 1'b1);
      i_bus_master.stop();
      rd(16'h8000, 1);
      d = {8'($urandom)};
      wr(ad, d, 1'b0);
      rd(ad, 1);
      rd(16'h4000, 16);
      wr(16'h4003, d, 1'b0);
      rd(16'h4003, 1);
      wr(16'hC005, d, 1'b1);
      rd(16'hC005, 1);
      d = {8'h02};
      wr(16'h8001, d, 1'b1);
      st(r);
      chk("locked", 32'h0000_0001, r[8]);
      d = {8'h5A};
      wr(16'hC005, d, 1'b0);
      rd(16'hC005, 1);
      apb(1'b1, 12'h000, 32'h0000_0000, r, e);
      apb(1'b0, 12'h000, 32'h0000_0000, r, e);
      chk("ctrl", 32'h0000_0000, r);
      dev(ca, 1'b0, 1'b1);
      i_bus_master.stop();
      end_of_test();
   end
endmodule : test_serial_eeprom_i2c_target
`default_nettype wire
